// [pkg/ata_cmd_pkg.sv]
// Shared constants and types of the card-side command front end.
// Assumes a 100 MHz core clock and the task-file offsets of the card.
package ata_cmd_pkg;
	// Clock and timing
	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned BUSY_SET_NS = 400;
	localparam int unsigned BUSY_CLR_NS = 400;
	localparam int unsigned DRQ_C2_US = 700;
	localparam int unsigned DRQ_C3_MS = 20;
	localparam int unsigned BUSY_SET_CYC = BUSY_SET_NS * CLK_MHZ / 1000;
	localparam int unsigned BUSY_CLR_CYC = BUSY_CLR_NS * CLK_MHZ / 1000;
	localparam int unsigned DRQ_C2_CYC = DRQ_C2_US * CLK_MHZ;
	localparam int unsigned DRQ_C3_CYC = DRQ_C3_MS * 1000 * CLK_MHZ;
	// Edges from accept to timer load, expiry flop and the DRQ edge;
	// with fewer, data request lands past the bound
	localparam int unsigned DRQ_MARGIN = 3;
	localparam int TMR_W = 21;

	// Task file offsets
	localparam logic [3:0] OFS_FEATURE = 4'h1;
	localparam logic [3:0] OFS_ERROR = 4'h1;
	localparam logic [3:0] OFS_SECT_CNT = 4'h2;
	localparam logic [3:0] OFS_SECT_NUM = 4'h3;
	localparam logic [3:0] OFS_CYL_LOW = 4'h4;
	localparam logic [3:0] OFS_CYL_HIGH = 4'h5;
	localparam logic [3:0] OFS_DRV_HEAD = 4'h6;
	localparam logic [3:0] OFS_COMMAND = 4'h7;
	localparam logic [3:0] OFS_STATUS = 4'h7;
	localparam logic [3:0] OFS_ALT_STAT = 4'hE;
	localparam logic [3:0] OFS_DEV_CTRL = 4'hE;

	// Field positions
	localparam int DH_DRV_BIT = 4;
	localparam int DC_SRST_BIT = 2;
	localparam int DC_NIEN_BIT = 1;

	// Reset values and fixed answers
	localparam logic [7:0] TF_RESET = 8'h00;
	localparam logic [7:0] STAT_BUSY_ONLY = 8'h80;
	localparam logic [7:0] SC_STANDBY = 8'h00;
	localparam logic [7:0] SC_IDLE = 8'hFF;
	localparam logic [7:0] DIAG_OK = 8'h01;
	localparam logic [3:0] DIAG_SLAVE_NIB = 4'h8;
	localparam logic [7:0] ERR_ABORT = 8'h04;

	typedef enum logic [2:0] {
		K_NOP, K_POWER, K_DIAG, K_ERASE, K_WRITE, K_EXT, K_BAD
	} cmd_kind_t;

	typedef logic [1:0] cls_t;
	localparam cls_t CLS_1 = 2'h1;
	localparam cls_t CLS_2 = 2'h2;
	localparam cls_t CLS_3 = 2'h3;
endpackage : ata_cmd_pkg

// [pkg/engine_if.sv]
// Carrier between the controller, the code classifier and the timer.
// Assumes all three parties run on the same core clock.
`timescale 1ns/1ns
interface engine_if;
	import ata_cmd_pkg::*;
	logic [7:0] code;
	cmd_kind_t kind;
	cls_t cls;
	logic tmr_start;
	logic [TMR_W-1:0] tmr_limit;
	logic tmr_expired;
	modport ctl (output code, tmr_start, tmr_limit,
		input kind, cls, tmr_expired);
	modport dec (input code, output kind, cls);
	modport tmr (input tmr_start, tmr_limit, output tmr_expired);
endinterface : engine_if

// [rtl/cmd_classify.sv]
// Combinational classifier of a command code into kind and class.
// Assumes the code is held stable in a register by the controller.
`timescale 1ns/1ns
module cmd_classify (
	engine_if.dec eng
);
	import ata_cmd_pkg::*;

	always_comb begin
		eng.cls = CLS_1;
		eng.kind = K_EXT;
		casez (eng.code)
			8'h00, 8'h1?, 8'h7?: eng.kind = K_NOP;
			8'h98, 8'hE5: eng.kind = K_POWER;
			8'h90: eng.kind = K_DIAG;
			8'hC0: eng.kind = K_ERASE;
			8'hEC, 8'hE3, 8'h97, 8'hE1, 8'h95, 8'h91, 8'hE4, 8'hC8,
			8'hC4, 8'h20, 8'h21, 8'h40, 8'h41, 8'h03, 8'hEF, 8'hC6,
			8'hE6, 8'h99, 8'hE2, 8'h96, 8'hE0, 8'h94, 8'h87,
			8'hF5: eng.kind = K_EXT;
			8'h30, 8'h31, 8'h38, 8'hE8, 8'hCA: begin
				eng.kind = K_WRITE;
				eng.cls = CLS_2;
			end
			8'hC5, 8'hCD, 8'h3C: begin
				eng.kind = K_WRITE;
				eng.cls = CLS_3;
			end
			default: eng.kind = K_BAD;
		endcase
	end
endmodule : cmd_classify

// [rtl/drq_deadline.sv]
// Down-counter that bounds the wait for the write buffer.
// Assumes start is a one-cycle pulse; expired holds until next start.
`timescale 1ns/1ns
module drq_deadline (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// Controller side
	engine_if.tmr eng
);
	import ata_cmd_pkg::*;

	logic [TMR_W-1:0] cnt_q;
	logic run_q;
	logic exp_q;

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			cnt_q <= '0;
			run_q <= 1'b0;
			exp_q <= 1'b0;
		end else if (eng.tmr_start) begin
			cnt_q <= eng.tmr_limit;
			run_q <= 1'b1;
			exp_q <= 1'b0;
		end else if (run_q) begin
			if (cnt_q <= TMR_W'(1)) begin
				run_q <= 1'b0;
				exp_q <= 1'b1;
			end else begin
				cnt_q <= cnt_q - TMR_W'(1);
			end
		end
	end

	assign eng.tmr_expired = exp_q;
endmodule : drq_deadline

// [rtl/ata_command_acceptance.sv]
// Card-side command front end: task file, acceptance and status flags.
// Assumes the host strobes are already synchronous to clock_i; straps
// and the slave-fail pin are asynchronous and resynchronised here.
`timescale 1ns/1ns
module ata_command_acceptance #(
	parameter int unsigned DRQ_C2_CYCLES = ata_cmd_pkg::DRQ_C2_CYC,
	parameter int unsigned DRQ_C3_CYCLES = ata_cmd_pkg::DRQ_C3_CYC
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// Task file access
	input wire logic [3:0] tf_addr_i,
	input wire logic tf_wr_i,
	input wire logic tf_rd_i,
	input wire logic [7:0] tf_wdata_i,
	output logic [7:0] tf_rdata_o,
	// Straps and pins
	input wire logic ide_mode_i,
	input wire logic card_number_i,
	input wire logic slave_fail_i,
	input wire logic standby_i,
	// Self test
	input wire logic [7:0] self_test_code_i,
	// Sector buffer
	output logic buf_setup_o,
	input wire logic buf_ready_i,
	input wire logic xfer_done_i,
	// Other command engines
	output logic ext_start_o,
	output logic [7:0] ext_code_o,
	input wire logic ext_done_i,
	input wire logic ext_error_i,
	// Erase engine
	output logic erase_start_o,
	output logic [27:0] erase_lba_o,
	output logic [7:0] erase_count_o,
	input wire logic erase_done_i,
	input wire logic erase_fault_i,
	// Status
	output logic card_busy_flag_o,
	output logic transfer_request_flag_o,
	output logic intrq_o
);
	import ata_cmd_pkg::*;

	typedef enum logic [5:0] {
		S_IDLE = 6'h01,
		S_DECODE = 6'h02,
		S_WAIT_BUF = 6'h04,
		S_WAIT_EXT = 6'h08,
		S_WAIT_ERASE = 6'h10,
		S_FINISH = 6'h20
	} state_t;

	function automatic logic [TMR_W-1:0] deadline(input int unsigned cyc);
		deadline = TMR_W'(cyc - DRQ_MARGIN);
	endfunction : deadline

	state_t state_q;
	logic [7:0] feature_param_q;
	logic [7:0] sector_count_q;
	logic [7:0] sector_number_q;
	logic [7:0] cylinder_low_q;
	logic [7:0] cylinder_high_q;
	logic [7:0] drive_head_select_q;
	logic [7:0] command_code_q;
	logic [7:0] error_q;
	logic [7:0] dev_ctrl_q;
	logic busy_q;
	logic drq_q;
	logic err_q;
	logic dwf_q;
	logic rdy_q;
	logic intrq_q;
	logic [7:0] rdata_q;
	logic buf_setup_q;
	logic ext_start_q;
	logic erase_start_q;
	logic tmr_start_q;
	logic [TMR_W-1:0] tmr_limit_q;
	logic [3:0] meta_q;
	logic [3:0] sync_q;
	logic rst_all;
	logic host_wr;
	logic cmd_wr;
	logic drive_match;
	logic accept;
	logic finish;
	logic [7:0] diag_result;
	logic [7:0] status_byte;

	engine_if eng ();

	cmd_classify u_classify (
		.eng(eng)
	);

	drq_deadline u_deadline (
		.clock_i(clock_i),
		.rst_i(rst_all),
		.eng(eng)
	);

	// Soft reset holds everything but the device control register, the resynchronisers and the read data register
	assign rst_all = sys_rst_i | dev_ctrl_q[DC_SRST_BIT];

	// Two-stage resynchronisers for the asynchronous straps and pins
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			meta_q <= 4'h0;
			sync_q <= 4'h0;
		end else begin
			meta_q <= {standby_i, slave_fail_i, card_number_i, ide_mode_i};
			sync_q <= meta_q;
		end
	end

	// Host writes reach the task file only while the card is not busy, except the device control register
	assign host_wr = tf_wr_i & ~busy_q;
	assign cmd_wr = host_wr & (tf_addr_i == OFS_COMMAND);
	assign drive_match = drive_head_select_q[DH_DRV_BIT] == sync_q[1];
	// IDE mode runs the diagnostic on both drives regardless of select
	assign accept = cmd_wr & (drive_match |
		(sync_q[0] & (tf_wdata_i == 8'h90)));
	assign finish = state_q == S_FINISH;

	// Only the master in IDE mode reports the slave's failure
	always_comb begin
		diag_result = self_test_code_i;
		if (sync_q[0] && !sync_q[1] && sync_q[2]) begin
			diag_result = {DIAG_SLAVE_NIB, self_test_code_i[3:0]};
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			dev_ctrl_q <= TF_RESET;
		end else if (tf_wr_i && tf_addr_i == OFS_DEV_CTRL) begin
			dev_ctrl_q <= tf_wdata_i;
		end
	end

	// Parameter registers; power query owns the sector count when busy
	always_ff @(posedge clock_i) begin
		if (rst_all) begin
			feature_param_q <= TF_RESET;
			sector_count_q <= TF_RESET;
			sector_number_q <= TF_RESET;
			cylinder_low_q <= TF_RESET;
			cylinder_high_q <= TF_RESET;
			drive_head_select_q <= TF_RESET;
		end else if (state_q == S_DECODE && eng.kind == K_POWER) begin
			if (sync_q[3]) begin
				sector_count_q <= SC_STANDBY;
			end else begin
				sector_count_q <= SC_IDLE;
			end
		end else if (host_wr) begin
			case (tf_addr_i)
				OFS_FEATURE: feature_param_q <= tf_wdata_i;
				OFS_SECT_CNT: sector_count_q <= tf_wdata_i;
				OFS_SECT_NUM: sector_number_q <= tf_wdata_i;
				OFS_CYL_LOW: cylinder_low_q <= tf_wdata_i;
				OFS_CYL_HIGH: cylinder_high_q <= tf_wdata_i;
				OFS_DRV_HEAD: drive_head_select_q <= tf_wdata_i;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_all) begin
			command_code_q <= TF_RESET;
		end else if (accept) begin
			command_code_q <= tf_wdata_i;
		end
	end

	assign eng.code = command_code_q;
	assign eng.tmr_start = tmr_start_q;
	assign eng.tmr_limit = tmr_limit_q;

	// Command sequencer
	always_ff @(posedge clock_i) begin
		if (rst_all) begin
			state_q <= S_IDLE;
		end else begin
			case (state_q)
				S_IDLE: begin
					if (accept) begin
						state_q <= S_DECODE;
					end
				end
				S_DECODE: begin
					case (eng.kind)
						K_WRITE: state_q <= S_WAIT_BUF;
						K_EXT: state_q <= S_WAIT_EXT;
						K_ERASE: state_q <= S_WAIT_ERASE;
						default: state_q <= S_FINISH;
					endcase
				end
				S_WAIT_BUF: begin
					if (buf_ready_i || eng.tmr_expired) begin
						state_q <= S_IDLE;
					end
				end
				S_WAIT_EXT: begin
					if (ext_done_i) begin
						state_q <= S_FINISH;
					end
				end
				S_WAIT_ERASE: begin
					if (erase_done_i) begin
						state_q <= S_FINISH;
					end
				end
				S_FINISH: state_q <= S_IDLE;
				default: state_q <= S_IDLE;
			endcase
		end
	end

	// Busy rises one cycle after the command write, well inside the bound
	always_ff @(posedge clock_i) begin
		if (rst_all) begin
			busy_q <= 1'b0;
		end else if (accept) begin
			busy_q <= 1'b1;
		end else if (state_q == S_WAIT_BUF &&
			(buf_ready_i || eng.tmr_expired)) begin
			busy_q <= 1'b0;
		end else if (finish) begin
			busy_q <= 1'b0;
		end
	end

	// Data request rises on the same edge that busy falls
	always_ff @(posedge clock_i) begin
		if (rst_all) begin
			drq_q <= 1'b0;
		end else if (accept) begin
			drq_q <= 1'b0;
		end else if (state_q == S_WAIT_BUF &&
			(buf_ready_i || eng.tmr_expired)) begin
			drq_q <= 1'b1;
		end else if (xfer_done_i) begin
			drq_q <= 1'b0;
		end
	end

	// Buffer setup and the deadline that bounds it
	always_ff @(posedge clock_i) begin
		if (rst_all) begin
			buf_setup_q <= 1'b0;
			tmr_start_q <= 1'b0;
			tmr_limit_q <= '0;
		end else begin
			buf_setup_q <= 1'b0;
			tmr_start_q <= 1'b0;
			if (state_q == S_DECODE && eng.kind == K_WRITE) begin
				buf_setup_q <= 1'b1;
				tmr_start_q <= 1'b1;
				if (eng.cls == CLS_3) begin
					tmr_limit_q <= deadline(DRQ_C3_CYCLES);
				end else begin
					tmr_limit_q <= deadline(DRQ_C2_CYCLES);
				end
			end
		end
	end

	// Erase moves no data; the head field forms the top address bits
	always_ff @(posedge clock_i) begin
		if (rst_all) begin
			erase_start_q <= 1'b0;
			erase_lba_o <= 28'h0000000;
			erase_count_o <= TF_RESET;
		end else begin
			erase_start_q <= 1'b0;
			if (state_q == S_DECODE && eng.kind == K_ERASE) begin
				erase_start_q <= 1'b1;
				erase_lba_o <= {drive_head_select_q[3:0], cylinder_high_q,
					cylinder_low_q, sector_number_q};
				erase_count_o <= sector_count_q;
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_all) begin
			ext_start_q <= 1'b0;
			ext_code_o <= TF_RESET;
		end else begin
			ext_start_q <= state_q == S_DECODE && eng.kind == K_EXT;
			ext_code_o <= command_code_q;
		end
	end

	// Error flag, write fault and error register
	always_ff @(posedge clock_i) begin
		if (rst_all) begin
			err_q <= 1'b0;
			dwf_q <= 1'b0;
			error_q <= DIAG_OK;
		end else if (accept) begin
			err_q <= 1'b0;
			dwf_q <= 1'b0;
		end else if (state_q == S_DECODE) begin
			if (eng.kind == K_BAD) begin
				err_q <= 1'b1;
				error_q <= ERR_ABORT;
			end else if (eng.kind == K_DIAG) begin
				error_q <= diag_result;
			end
		end else if (state_q == S_WAIT_ERASE && erase_done_i) begin
			err_q <= erase_fault_i;
			dwf_q <= erase_fault_i;
		end else if (state_q == S_WAIT_EXT && ext_done_i) begin
			err_q <= ext_error_i;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_all) begin
			rdy_q <= 1'b0;
		end else begin
			rdy_q <= 1'b1;
		end
	end

	// A completion in the same cycle as a status read stays pending
	always_ff @(posedge clock_i) begin
		if (rst_all) begin
			intrq_q <= 1'b0;
		end else if (finish && !dev_ctrl_q[DC_NIEN_BIT]) begin
			intrq_q <= 1'b1;
		end else if (tf_rd_i && tf_addr_i == OFS_STATUS) begin
			intrq_q <= 1'b0;
		end
	end

	// While busy no other status bit is meaningful, so they read zero
	always_comb begin
		status_byte = {busy_q, rdy_q, dwf_q, rdy_q, drq_q, 2'h0, err_q};
		if (busy_q) begin
			status_byte = STAT_BUSY_ONLY;
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			rdata_q <= TF_RESET;
		end else if (tf_rd_i) begin
			case (tf_addr_i)
				OFS_ERROR: rdata_q <= busy_q ? TF_RESET : error_q;
				OFS_SECT_CNT: rdata_q <= sector_count_q;
				OFS_SECT_NUM: rdata_q <= sector_number_q;
				OFS_CYL_LOW: rdata_q <= cylinder_low_q;
				OFS_CYL_HIGH: rdata_q <= cylinder_high_q;
				OFS_DRV_HEAD: rdata_q <= drive_head_select_q;
				OFS_STATUS: rdata_q <= status_byte;
				OFS_ALT_STAT: rdata_q <= status_byte;
				default: rdata_q <= TF_RESET;
			endcase
		end
	end

	assign tf_rdata_o = rdata_q;
	assign buf_setup_o = buf_setup_q;
	assign ext_start_o = ext_start_q;
	assign erase_start_o = erase_start_q;
	assign card_busy_flag_o = busy_q;
	assign transfer_request_flag_o = drq_q;
	assign intrq_o = intrq_q;
endmodule : ata_command_acceptance

// [verification/ata_command_acceptance_assertions.sv]
// Checker of busy, data request and status timing at the top ports.
// Assumes single-cycle host strobes synchronous to clock_i.
`timescale 1ns/1ns
module ata_command_acceptance_assertions #(
	parameter int unsigned DRQ_C2_CYCLES = 20,
	parameter int unsigned DRQ_C3_CYCLES = 40
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// Task file and status
	input wire logic [3:0] tf_addr_i,
	input wire logic tf_wr_i,
	input wire logic tf_rd_i,
	input wire logic [7:0] tf_wdata_i,
	input wire logic [7:0] tf_rdata_o,
	input wire logic card_number_i,
	input wire logic buf_setup_o,
	input wire logic card_busy_flag_o,
	input wire logic transfer_request_flag_o,
	input wire logic intrq_o
);
	import ata_cmd_pkg::*;
	localparam int C2_HI = DRQ_C2_CYCLES + 1;
	localparam int C3_HI = DRQ_C3_CYCLES + 1;
	logic drv_q;
	logic nien_q;
	logic acc;
	logic w2;
	logic w3;
	// Shadow of drive select, so only commands for this card count
	assign acc = tf_wr_i && tf_addr_i == OFS_COMMAND && !card_busy_flag_o
		&& drv_q == card_number_i;
	assign w2 = tf_wdata_i inside {8'h30, 8'h31, 8'h38, 8'hE8, 8'hCA};
	assign w3 = tf_wdata_i inside {8'hC5, 8'hCD, 8'h3C};
	always_ff @(posedge clock_i) begin
		if (sys_rst_i)
			drv_q <= 1'b0;
		else if (tf_wr_i && tf_addr_i == OFS_DRV_HEAD && !card_busy_flag_o)
			drv_q <= tf_wdata_i[DH_DRV_BIT];
	end
	always_ff @(posedge clock_i) begin
		if (sys_rst_i)
			nien_q <= 1'b0;
		else if (tf_wr_i && tf_addr_i == OFS_DEV_CTRL)
			nien_q <= tf_wdata_i[DC_NIEN_BIT];
	end
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);
	property p_busy_set;
		acc |=> card_busy_flag_o [*2];
	endproperty
	a_busy_set: assert property (p_busy_set)
		else $error("busy not raised after command");
	property p_nop_done;
		acc && tf_wdata_i == 8'h00 && !nien_q
			|-> ##[2:4] (!card_busy_flag_o && intrq_o);
	endproperty
	a_nop_done: assert property (p_nop_done)
		else $error("no-operation did not complete");
	property p_setup;
		acc && (w2 || w3) |-> ##2 buf_setup_o;
	endproperty
	a_setup: assert property (p_setup)
		else $error("buffer setup missing");
	property p_c2_drq;
		acc && w2 |-> ##[3:C2_HI] transfer_request_flag_o;
	endproperty
	a_c2_drq: assert property (p_c2_drq)
		else $error("class 2 data request late");
	property p_c3_drq;
		acc && w3 |-> ##[3:C3_HI] transfer_request_flag_o;
	endproperty
	a_c3_drq: assert property (p_c3_drq)
		else $error("class 3 data request late");
	property p_drq_busy;
		$rose(transfer_request_flag_o) |-> $fell(card_busy_flag_o);
	endproperty
	a_drq_busy: assert property (p_drq_busy)
		else $error("busy not dropped with data request");
	property p_drq_clr;
		acc |=> !transfer_request_flag_o;
	endproperty
	a_drq_clr: assert property (p_drq_clr)
		else $error("data request survived command");
	property p_stat_busy;
		tf_rd_i && tf_addr_i == OFS_STATUS && card_busy_flag_o
			|=> tf_rdata_o == STAT_BUSY_ONLY;
	endproperty
	a_stat_busy: assert property (p_stat_busy)
		else $error("status while busy not busy only");
	property p_stat_clr;
		tf_rd_i && tf_addr_i == OFS_STATUS && !card_busy_flag_o |=> !intrq_o;
	endproperty
	a_stat_clr: assert property (p_stat_clr)
		else $error("status read kept interrupt");
	property p_alt_keep;
		tf_rd_i && tf_addr_i == OFS_ALT_STAT && intrq_o |=> intrq_o;
	endproperty
	a_alt_keep: assert property (p_alt_keep)
		else $error("alternate status cleared interrupt");
endmodule : ata_command_acceptance_assertions
bind ata_command_acceptance ata_command_acceptance_assertions #(
	.DRQ_C2_CYCLES(DRQ_C2_CYCLES),
	.DRQ_C3_CYCLES(DRQ_C3_CYCLES)
) u_chk (.*);

// [verification/engine_model.sv]
// Model of the sector buffer and command engines behind the front end.
// Assumes one-cycle start pulses; a delay of zero never answers.
`timescale 1ns/1ns
module engine_model (
	// Clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// Starts from the front end
	input wire logic buf_setup_o,
	input wire logic ext_start_o,
	input wire logic erase_start_o,
	// Bench controls
	input wire logic [7:0] delay_i,
	input wire logic fault_i,
	// Answers
	output logic buf_ready_i,
	output logic ext_done_i,
	output logic ext_error_i,
	output logic erase_done_i,
	output logic erase_fault_i
);
	logic [7:0] cnt_q;
	logic [2:0] kind_q;
	logic fin;
	assign fin = cnt_q == 8'h01;
	assign buf_ready_i = fin & kind_q[0];
	assign ext_done_i = fin & kind_q[1];
	assign erase_done_i = fin & kind_q[2];
	// Inverted outside done, so a stale sample shows up
	assign ext_error_i = ext_done_i ? fault_i : ~fault_i;
	assign erase_fault_i = erase_done_i ? fault_i : ~fault_i;
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			cnt_q <= 8'h00;
			kind_q <= 3'h0;
		end else if (buf_setup_o | ext_start_o | erase_start_o) begin
			cnt_q <= delay_i;
			kind_q <= {erase_start_o, ext_start_o, buf_setup_o};
		end else if (cnt_q != 8'h00) begin
			cnt_q <= cnt_q - 8'h01;
		end
	end
endmodule : engine_model

// [verification/ata_command_acceptance_tb.sv]
// Bench acting as host on the task file, with an engine model behind.
// Assumes shortened data request deadlines of 20 and 40 cycles.
`timescale 1ns/1ns
module ata_command_acceptance_tb;
	import ata_cmd_pkg::*;
	localparam int unsigned C2 = 20;
	localparam int unsigned C3 = 40;
	logic clock_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [3:0] tf_addr_i = 4'h0;
	logic tf_wr_i = 1'b0;
	logic tf_rd_i = 1'b0;
	logic [7:0] tf_wdata_i = 8'h00;
	logic ide_mode_i = 1'b0;
	logic card_number_i = 1'b0;
	logic slave_fail_i = 1'b0;
	logic standby_i = 1'b0;
	logic [7:0] self_test_code_i = 8'h01;
	logic xfer_done_i = 1'b0;
	logic [7:0] delay_i = 8'h04;
	logic fault_i = 1'b0;
	logic [7:0] tf_rdata_o, ext_code_o, erase_count_o, v;
	logic [27:0] erase_lba_o;
	logic buf_setup_o, buf_ready_i, ext_start_o, ext_done_i, ext_error_i;
	logic erase_start_o, erase_done_i, erase_fault_i;
	logic card_busy_flag_o, transfer_request_flag_o, intrq_o;
	logic [7:0] nops[3] = '{8'h00, 8'h1F, 8'h70};
	logic [7:0] wc[8] = '{8'h30, 8'h31, 8'h38, 8'hE8, 8'hCA,
		8'hC5, 8'hCD, 8'h3C};
	logic [7:0] ep[5] = '{8'h05, 8'h11, 8'h22, 8'h33, 8'hE4};
	int fails = 0;
	int total_checks = 0;
	int n;
	always #5 clock_i = ~clock_i;
	ata_command_acceptance #(.DRQ_C2_CYCLES(C2), .DRQ_C3_CYCLES(C3)) DUT (.*);
	engine_model u_eng (.*);
	task automatic end_of_test();
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_of_test
	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk8
	task automatic chk1(input logic g, input logic e);
		chk8({7'h00, g}, {7'h00, e});
	endtask : chk1
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock_i);
		tf_addr_i <= a;
		tf_wdata_i <= d;
		tf_wr_i <= 1'b1;
		@(posedge clock_i);
		tf_wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a);
		@(posedge clock_i);
		tf_addr_i <= a;
		tf_rd_i <= 1'b1;
		@(posedge clock_i);
		tf_rd_i <= 1'b0;
		#1 v = tf_rdata_o;
	endtask : rd
	task automatic rc(input logic [3:0] a, input logic [7:0] e);
		rd(a);
		chk8(v, e);
	endtask : rc
	// Counts edges from the command edge; bounded against hangs
	task automatic wt(input bit s);
		for (n = 1; n < 200; n++) begin
			@(posedge clock_i);
			#1;
			if (s ? transfer_request_flag_o === 1'b1
				: card_busy_flag_o === 1'b0)
				break;
		end
		if (n == 200) begin
			fails++;
			$display("CHECK FAILED t=%0t wait ran out", $time);
			end_of_test();
		end
	endtask : wt
	task automatic diag(input logic [7:0] dh, input logic [7:0] e);
		wr(OFS_DRV_HEAD, dh);
		repeat (3) @(posedge clock_i);
		wr(OFS_COMMAND, 8'h90);
		wt(0);
		rc(OFS_ERROR, e);
	endtask : diag
	initial begin
		repeat (20) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		repeat (3) @(posedge clock_i);
		rc(OFS_SECT_CNT, TF_RESET);
		rc(OFS_ERROR, DIAG_OK);
		rc(OFS_STATUS, 8'h50);
		foreach (nops[i]) begin
			wr(OFS_COMMAND, nops[i]);
			wt(0);
			chk1(intrq_o, 1'b1);
			rc(OFS_ALT_STAT, 8'h50);
			chk1(intrq_o, 1'b1);
			rc(OFS_STATUS, 8'h50);
			chk1(intrq_o, 1'b0);
		end
		for (int i = 0; i < 4; i++) begin
			@(posedge clock_i) standby_i <= i[0];
			repeat (3) @(posedge clock_i);
			wr(OFS_COMMAND, i[1] ? 8'hE5 : 8'h98);
			wt(0);
			rc(OFS_SECT_CNT, i[0] ? SC_STANDBY : SC_IDLE);
		end
		wr(OFS_COMMAND, 8'hFF);
		wt(0);
		rc(OFS_STATUS, 8'h51);
		rc(OFS_ERROR, ERR_ABORT);
		wr(OFS_COMMAND, 8'h00);
		wt(0);
		rc(OFS_STATUS, 8'h50);
		@(posedge clock_i) self_test_code_i <= 8'h03;
		diag(8'hA0, 8'h03);
		@(posedge clock_i) self_test_code_i <= 8'h05;
		ide_mode_i <= 1'b1;
		slave_fail_i <= 1'b1;
		diag(8'hB0, 8'h85);
		@(posedge clock_i) self_test_code_i <= 8'h02;
		ide_mode_i <= 1'b0;
		diag(8'hB0, 8'h85);
		chk1(card_busy_flag_o, 1'b0);
		@(posedge clock_i) slave_fail_i <= 1'b0;
		wr(OFS_DRV_HEAD, 8'hA0);
		foreach (wc[i]) begin
			wr(OFS_COMMAND, wc[i]);
			wr(OFS_SECT_CNT, 8'h5A);
			rc(OFS_STATUS, STAT_BUSY_ONLY);
			wt(1);
			chk1(card_busy_flag_o, 1'b0);
			@(posedge clock_i) xfer_done_i <= 1'b1;
			@(posedge clock_i) xfer_done_i <= 1'b0;
			#1 chk1(transfer_request_flag_o, 1'b0);
		end
		rc(OFS_SECT_CNT, SC_STANDBY);
		@(posedge clock_i) delay_i <= 8'h00;
		for (int i = 0; i < 2; i++) begin
			wr(OFS_COMMAND, i ? 8'hC5 : 8'h30);
			wt(1);
			chk1(n <= (i ? C3 : C2), 1'b1);
		end
		wr(OFS_COMMAND, 8'h00);
		wt(0);
		chk1(transfer_request_flag_o, 1'b0);
		rc(OFS_STATUS, 8'h50);
		@(posedge clock_i) delay_i <= 8'h03;
		fault_i <= 1'b1;
		foreach (ep[i])
			wr(OFS_SECT_CNT + 4'(i), ep[i]);
		wr(OFS_COMMAND, 8'hC0);
		wt(0);
		chk8(erase_count_o, 8'h05);
		chk1(erase_lba_o === 28'h4332211, 1'b1);
		rd(OFS_STATUS);
		chk8(v & 8'h20, 8'h20);
		@(posedge clock_i) fault_i <= 1'b0;
		wr(OFS_DRV_HEAD, 8'hAF);
		wr(OFS_COMMAND, 8'hEC);
		wt(0);
		chk8(ext_code_o, 8'hEC);
		chk1(intrq_o, 1'b1);
		rc(OFS_STATUS, 8'h50);
		wr(OFS_DEV_CTRL, 8'h02);
		wr(OFS_COMMAND, 8'h00);
		wt(0);
		chk1(intrq_o, 1'b0);
		wr(OFS_DEV_CTRL, 8'h00);
		// Soft reset: task file and error register back to reset values
		wr(OFS_DEV_CTRL, 8'h04);
		wr(OFS_DEV_CTRL, 8'h00);
		rc(OFS_STATUS, 8'h50);
		rc(OFS_SECT_CNT, TF_RESET);
		rc(OFS_ERROR, DIAG_OK);
		end_of_test();
	end
endmodule : ata_command_acceptance_tb
